/* File: include/emb_pkg.sv */
// constants and encodings for the external memory bus and control pins
package emb_pkg;
    // -------------------------------------------------------------
    // timing, counted in oscillator periods (mclk is the oscillator), except RST_IN_MC in machine cycles
    // -------------------------------------------------------------
    localparam int OSC_PER_MC = 6;
    localparam int RST_IN_MC = 2;
    localparam int RST_IN_CNT = RST_IN_MC * OSC_PER_MC;
    localparam int RST_OUT_OSC = 98;
    localparam int RST_OUT_CNT = RST_OUT_OSC * 1;
    localparam logic [2:0] PH_ALE = 3'h0;
    localparam logic [2:0] PH_FETCH_A = 3'h2;
    localparam logic [2:0] PH_STB_FIRST = 3'h2;
    localparam logic [2:0] PH_STB_LAST = 3'h4;
    localparam logic [2:0] PH_FETCH_B = 3'h5;
    localparam logic [2:0] PH_LAST = 3'h5;
    // -------------------------------------------------------------
    // register indices; byte address is four times the index
    // -------------------------------------------------------------
    localparam logic [7:0] IDX_LOW_PORT = 8'h80;
    localparam logic [7:0] IDX_AUX = 8'h8e;
    localparam logic [7:0] IDX_HIGH_PORT = 8'ha0;
    localparam logic [7:0] IDX_P3 = 8'hb0;
    localparam logic [7:0] IDX_XADL = 8'hf9;
    localparam logic [7:0] IDX_XADH = 8'hfa;
    localparam logic [7:0] IDX_XDAT = 8'hfb;
    localparam logic [7:0] IDX_XCTL = 8'hfc;
    localparam logic [7:0] IDX_XSTA = 8'hfd;
    // -------------------------------------------------------------
    // fields and reset values
    // -------------------------------------------------------------
    localparam int AUX_ALE_OFF = 0;
    localparam int AUX_EXTRAM = 1;
    localparam int AUX_RTO_OFF = 3;
    localparam logic [7:0] AUX_MASK = 8'h1b;
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'hff;
    localparam int XCTL_START = 0;
    localparam int XCTL_WRITE = 1;
    localparam int XCTL_PAIR = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // -------------------------------------------------------------
    // machine cycle kinds
    // -------------------------------------------------------------
    typedef enum logic [1:0] {MC_NORMAL, MC_ACCESS, MC_TURN} emb_kind_t;
endpackage : emb_pkg

/* File: src/emb_ext_bus.sv */
// external memory bus, port pins, reset pin and fetch strap control
`timescale 1ns/1ps
module emb_ext_bus (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // axi4-lite slave
    input wire logic [9:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [9:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // core side
    input wire logic [15:0] pc_addr,
    input wire logic code_move_active,
    input wire logic watchdog_timeout,
    input wire logic lock_bit1,
    output logic [7:0] code_byte,
    output logic code_valid,
    output logic core_reset,
    // pins
    input wire logic external_fetch_select,
    input wire logic [7:0] low_addr_data_port_i,
    output logic [7:0] low_addr_data_port_o,
    output logic [7:0] low_addr_data_port_oe,
    input wire logic [7:0] high_addr_port_i,
    output logic [7:0] high_addr_port_o,
    output logic [7:0] high_addr_port_oe,
    input wire logic [7:0] p3_i,
    output logic [7:0] p3_o,
    output logic [7:0] p3_oe,
    output logic ale_o,
    output logic ale_oe,
    output logic program_fetch_strobe_n,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe
);
    localparam int RIN_W = $clog2(emb_pkg::RST_IN_CNT + 1);
    localparam int ROUT_W = $clog2(emb_pkg::RST_OUT_CNT + 1);

    if (emb_pkg::OSC_PER_MC != int'(emb_pkg::PH_LAST) + 1) begin : g_bad_phase
        $error("machine cycle length does not match phase constants");
    end

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [2:0] phase;
        emb_pkg::emb_kind_t kind;
        logic [7:0] aux;
        logic [7:0] p0l;
        logic [7:0] p2l;
        logic [7:0] p3l;
        logic [15:0] xaddr;
        logic [7:0] xdata;
        logic xwr;
        logic xdptr;
        logic xpend;
        logic [RIN_W-1:0] rin_cnt;
        logic [ROUT_W-1:0] rout_cnt;
        logic core_rst;
        logic strap_cap;
        logic strap_done;
        logic awh;
        logic wh;
        logic wen;
        logic [7:0] awa;
        logic [7:0] wd;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic ale;
        logic ale_oe;
        logic fstb_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] p0o;
        logic [7:0] p0oe;
        logic [7:0] p2o;
        logic [7:0] p2oe;
        logic [7:0] p3o;
        logic [7:0] p3oe;
        logic rsto_oe;
        logic [7:0] code;
        logic cvalid;
    } emb_state_t;

    emb_state_t st_reg;
    emb_state_t st_next;
    logic [7:0] xram [256];
    logic ram_we;
    logic strap_eff;
    logic ext_exec;
    logic busy;
    logic ale_en;
    logic strobe;

    function automatic logic reg_hit(input logic [7:0] idx);
        unique case (idx)
            emb_pkg::IDX_LOW_PORT, emb_pkg::IDX_AUX, emb_pkg::IDX_HIGH_PORT, emb_pkg::IDX_P3,
            emb_pkg::IDX_XADL, emb_pkg::IDX_XADH, emb_pkg::IDX_XDAT,
            emb_pkg::IDX_XCTL, emb_pkg::IDX_XSTA: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction : reg_hit

    // a quasi-bidirectional bit driven only while its value is zero
    function automatic logic [7:0] quasi_oe(input logic [7:0] v);
        quasi_oe = ~v;
    endfunction : quasi_oe

    assign strap_eff = (lock_bit1 && st_reg.strap_done) ? st_reg.strap_cap : external_fetch_select;
    assign ext_exec = !strap_eff;
    assign busy = st_reg.xpend || (st_reg.kind == emb_pkg::MC_ACCESS);

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        ram_we = 1'b0;
        // machine cycle sequencing; an access always starts on a cycle boundary
        st_next.phase = (st_reg.phase == emb_pkg::PH_LAST) ? 3'h0 : 3'(st_reg.phase + 3'h1);
        if (st_reg.phase == emb_pkg::PH_LAST) begin
            if (st_reg.kind == emb_pkg::MC_ACCESS) begin
                st_next.kind = emb_pkg::MC_TURN;
            end else if (st_reg.xpend) begin
                st_next.kind = emb_pkg::MC_ACCESS;
                st_next.xpend = 1'b0;
            end else begin
                st_next.kind = emb_pkg::MC_NORMAL;
            end
        end
        // latch pulse; the cycle after an access carries none
        ale_en = !st_reg.aux[emb_pkg::AUX_ALE_OFF] || ext_exec || code_move_active
            || (st_reg.kind == emb_pkg::MC_ACCESS);
        st_next.ale = (st_reg.phase == emb_pkg::PH_ALE) && (st_reg.kind != emb_pkg::MC_TURN) && ale_en;
        st_next.ale_oe = ale_en;
        st_next.fstb_n = !(ext_exec && (st_reg.kind != emb_pkg::MC_ACCESS)
            && (st_reg.phase == emb_pkg::PH_FETCH_A || st_reg.phase == emb_pkg::PH_FETCH_B));
        strobe = (st_reg.kind == emb_pkg::MC_ACCESS) && (st_reg.phase >= emb_pkg::PH_STB_FIRST)
            && (st_reg.phase <= emb_pkg::PH_STB_LAST);
        st_next.rd_n = !(strobe && !st_reg.xwr);
        st_next.wr_n = !(strobe && st_reg.xwr);
        // port 0: address, then data, else floating for reads or plain port
        if (st_reg.kind == emb_pkg::MC_ACCESS && st_reg.phase == emb_pkg::PH_ALE) begin
            st_next.p0o = st_reg.xaddr[7:0];
            st_next.p0oe = 8'hff;
        end else if (st_reg.kind == emb_pkg::MC_ACCESS && st_reg.xwr
            && st_reg.phase != emb_pkg::PH_LAST) begin
            st_next.p0o = st_reg.xdata;
            st_next.p0oe = 8'hff;
        end else if (ext_exec && st_reg.phase == emb_pkg::PH_ALE) begin
            st_next.p0o = pc_addr[7:0];
            st_next.p0oe = 8'hff;
        end else if (ext_exec || st_reg.kind == emb_pkg::MC_ACCESS) begin
            st_next.p0o = 8'h00;
            st_next.p0oe = 8'h00;
        end else begin
            st_next.p0o = 8'h00;
            st_next.p0oe = quasi_oe(st_reg.p0l);
        end
        // port 2: address bytes are driven strongly, latch contents weakly
        if (st_reg.kind == emb_pkg::MC_ACCESS && st_reg.xdptr) begin
            st_next.p2o = st_reg.xaddr[15:8];
            st_next.p2oe = 8'hff;
        end else if (st_reg.kind == emb_pkg::MC_ACCESS) begin
            st_next.p2o = st_reg.p2l;
            st_next.p2oe = quasi_oe(st_reg.p2l);
        end else if (ext_exec) begin
            st_next.p2o = pc_addr[15:8];
            st_next.p2oe = 8'hff;
        end else begin
            st_next.p2o = st_reg.p2l;
            st_next.p2oe = quasi_oe(st_reg.p2l);
        end
        st_next.p3o = st_reg.p3l & {st_next.rd_n, st_next.wr_n, 6'h3f};
        st_next.p3oe = quasi_oe(st_next.p3o);
        // sample code while the strobe is low on the pin, read data late in the strobe
        st_next.cvalid = !st_reg.fstb_n;
        if (!st_reg.fstb_n) begin
            st_next.code = low_addr_data_port_i;
        end
        if (st_reg.kind == emb_pkg::MC_ACCESS && !st_reg.xwr && st_reg.phase == emb_pkg::PH_STB_LAST) begin
            st_next.xdata = low_addr_data_port_i;
        end
        // reset pin in and out; the pin reads high while we drive it, so a timeout resets the core
        if (!rst_pin_i) begin
            st_next.rin_cnt = '0;
        end else if (st_reg.rin_cnt != RIN_W'(emb_pkg::RST_IN_CNT)) begin
            st_next.rin_cnt = RIN_W'(st_reg.rin_cnt + 1'b1);
        end
        st_next.core_rst = (st_next.rin_cnt == RIN_W'(emb_pkg::RST_IN_CNT));
        if (watchdog_timeout && !st_reg.aux[emb_pkg::AUX_RTO_OFF]) begin
            st_next.rout_cnt = ROUT_W'(emb_pkg::RST_OUT_CNT);
        end else if (st_reg.rout_cnt != '0) begin
            st_next.rout_cnt = ROUT_W'(st_reg.rout_cnt - 1'b1);
        end
        st_next.rsto_oe = (st_next.rout_cnt != '0);
        // strap is caught once, on the first edge after reset release
        if (!st_reg.strap_done) begin
            st_next.strap_cap = external_fetch_select;
            st_next.strap_done = 1'b1;
        end
        // bus write channels, taken in either order
        if (awvalid && st_reg.awready) begin
            st_next.awh = 1'b1;
            st_next.awa = awaddr[9:2];
        end
        if (wvalid && st_reg.wready) begin
            st_next.wh = 1'b1;
            st_next.wd = wdata[7:0];
            st_next.wen = wstrb[0];
        end
        if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.awh && st_reg.wh && !st_reg.bvalid) begin
            st_next.awh = 1'b0;
            st_next.wh = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = reg_hit(st_reg.awa) ? emb_pkg::RESP_OKAY : emb_pkg::RESP_SLVERR;
            if (st_reg.wen) begin
                unique case (st_reg.awa)
                    emb_pkg::IDX_LOW_PORT: st_next.p0l = st_reg.wd;
                    emb_pkg::IDX_HIGH_PORT: st_next.p2l = st_reg.wd;
                    emb_pkg::IDX_P3: st_next.p3l = st_reg.wd;
                    emb_pkg::IDX_AUX: st_next.aux = st_reg.wd & emb_pkg::AUX_MASK;
                    // transfer setup is frozen while an access is under way
                    emb_pkg::IDX_XADL: if (!busy) st_next.xaddr[7:0] = st_reg.wd;
                    emb_pkg::IDX_XADH: if (!busy) st_next.xaddr[15:8] = st_reg.wd;
                    emb_pkg::IDX_XDAT: if (!busy) st_next.xdata = st_reg.wd;
                    emb_pkg::IDX_XCTL: begin
                        if (st_reg.wd[emb_pkg::XCTL_START] && !busy) begin
                            if (!st_reg.aux[emb_pkg::AUX_EXTRAM] && st_reg.xaddr[15:8] == 8'h00) begin
                                ram_we = st_reg.wd[emb_pkg::XCTL_WRITE];
                                if (!st_reg.wd[emb_pkg::XCTL_WRITE]) begin
                                    st_next.xdata = xram[st_reg.xaddr[7:0]];
                                end
                            end else begin
                                st_next.xpend = 1'b1;
                                st_next.xwr = st_reg.wd[emb_pkg::XCTL_WRITE];
                                st_next.xdptr = st_reg.wd[emb_pkg::XCTL_PAIR];
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
        st_next.awready = !st_next.awh && !st_next.bvalid;
        st_next.wready = !st_next.wh && !st_next.bvalid;
        // bus read channel; ports read back their pins
        if (arvalid && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rresp = reg_hit(araddr[9:2]) ? emb_pkg::RESP_OKAY : emb_pkg::RESP_SLVERR;
            unique case (araddr[9:2])
                emb_pkg::IDX_LOW_PORT: st_next.rdata = low_addr_data_port_i;
                emb_pkg::IDX_HIGH_PORT: st_next.rdata = high_addr_port_i;
                emb_pkg::IDX_P3: st_next.rdata = p3_i;
                emb_pkg::IDX_AUX: st_next.rdata = st_reg.aux;
                emb_pkg::IDX_XADL: st_next.rdata = st_reg.xaddr[7:0];
                emb_pkg::IDX_XADH: st_next.rdata = st_reg.xaddr[15:8];
                emb_pkg::IDX_XDAT: st_next.rdata = st_reg.xdata;
                emb_pkg::IDX_XCTL: st_next.rdata = {5'h00, st_reg.xdptr, st_reg.xwr, 1'b0};
                emb_pkg::IDX_XSTA: st_next.rdata = {5'h00, st_reg.rsto_oe, ext_exec, busy};
                default: st_next.rdata = 8'h00;
            endcase
        end else if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
            st_next.arready = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.aux <= emb_pkg::AUX_RST;
            st_reg.p0l <= emb_pkg::PORT_RST;
            st_reg.p2l <= emb_pkg::PORT_RST;
            st_reg.p3l <= emb_pkg::PORT_RST;
            st_reg.p2o <= emb_pkg::PORT_RST;
            st_reg.p3o <= emb_pkg::PORT_RST;
            st_reg.fstb_n <= 1'b1;
            st_reg.rd_n <= 1'b1;
            st_reg.wr_n <= 1'b1;
            st_reg.ale_oe <= 1'b1;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (ram_we) begin
            xram[st_reg.xaddr[7:0]] <= st_reg.xdata;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign awready = st_reg.awready;
    assign wready = st_reg.wready;
    assign bresp = st_reg.bresp;
    assign bvalid = st_reg.bvalid;
    assign arready = st_reg.arready;
    assign rdata = {24'h000000, st_reg.rdata};
    assign rresp = st_reg.rresp;
    assign rvalid = st_reg.rvalid;
    assign code_byte = st_reg.code;
    assign code_valid = st_reg.cvalid;
    assign core_reset = st_reg.core_rst;
    assign low_addr_data_port_o = st_reg.p0o;
    assign low_addr_data_port_oe = st_reg.p0oe;
    assign high_addr_port_o = st_reg.p2o;
    assign high_addr_port_oe = st_reg.p2oe;
    assign p3_o = st_reg.p3o;
    assign p3_oe = st_reg.p3oe;
    assign ale_o = st_reg.ale;
    assign ale_oe = st_reg.ale_oe;
    assign program_fetch_strobe_n = st_reg.fstb_n;
    assign rst_pin_o = st_reg.rsto_oe;
    assign rst_pin_oe = st_reg.rsto_oe;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    localparam int RIN_LAST = emb_pkg::RST_IN_CNT - 1;
    logic [7:0] oe_len;
    always_ff @(posedge mclk) begin
        if (!nrst || !st_reg.rsto_oe) oe_len <= 8'h00;
        else oe_len <= 8'(oe_len + 8'h01);
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // second strobe owed only if still external when it is computed
    sequence s_two_fetches;
        !st_reg.fstb_n ##3 (!st_reg.fstb_n || !$past(ext_exec));
    endsequence

    a_ale_rate: assert property ($rose(st_reg.ale) |-> st_reg.phase == 3'h1)
        else $error("latch pulse off its phase");
    a_ale_skip: assert property (st_reg.kind == emb_pkg::MC_TURN && st_reg.phase == 3'h1 |-> !st_reg.ale)
        else $error("latch pulse not omitted after access");
    a_ale_disable: assert property (st_reg.aux[0] && !ext_exec && !code_move_active
        && st_reg.kind == emb_pkg::MC_NORMAL |=> !st_reg.ale_oe)
        else $error("latch pin driven while disabled");
    a_fetch_twice: assert property (ext_exec && st_reg.phase == 3'h2 && st_reg.kind != emb_pkg::MC_ACCESS
        && $stable(ext_exec) [*1] ##1 ext_exec |-> s_two_fetches)
        else $error("fetch strobe not twice per cycle");
    a_fetch_skip: assert property (st_reg.kind == emb_pkg::MC_ACCESS |=> st_reg.fstb_n)
        else $error("fetch strobe during data access");
    a_p2_pointer: assert property (st_reg.kind == emb_pkg::MC_ACCESS && st_reg.xdptr && st_reg.phase == 3'h2
        |-> high_addr_port_o == st_reg.xaddr[15:8] && high_addr_port_oe == 8'hff)
        else $error("high address missing");
    a_p2_latch: assert property (st_reg.kind == emb_pkg::MC_ACCESS && !st_reg.xdptr && st_reg.phase == 3'h2
        && $stable(st_reg.p2l) |-> high_addr_port_o == st_reg.p2l)
        else $error("port 2 latch not shown");
    a_wr_strobe: assert property (st_reg.kind == emb_pkg::MC_ACCESS && st_reg.xwr && st_reg.phase == 3'h3
        |-> !p3_o[6] && p3_oe[6] && p3_o[7] && low_addr_data_port_o == st_reg.xdata)
        else $error("write strobe or data wrong");
    a_rst_out_start: assert property (watchdog_timeout && !st_reg.aux[3] |=> rst_pin_oe [*8])
        else $error("reset out not started");
    a_rst_out_len: assert property ($fell(st_reg.rsto_oe) |-> $past(oe_len) == 8'(emb_pkg::RST_OUT_CNT - 1)
        || $past(watchdog_timeout, 2))
        else $error("reset out length wrong");
    a_rst_in: assert property ($rose(st_reg.core_rst) |-> $past(st_reg.rin_cnt) == RIN_W'(RIN_LAST))
        else $error("core reset before two machine cycles");
    a_strap_hold: assert property (lock_bit1 && $past(lock_bit1) && st_reg.strap_done && $past(st_reg.strap_done)
        |-> $stable(strap_eff))
        else $error("strap changed under lock");
endmodule : emb_ext_bus

/* File: tb/emb_ext_bus_bench.sv */
// self-checking bench for the external memory bus block
`timescale 1ns/1ps
module emb_ext_bus_bench;
    // ---------------------------------
    // signals
    // ---------------------------------
    logic mclk = 1'h0, nrst = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [9:0] awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [15:0] pc_addr = 16'h1234;
    logic code_move_active = 1'h0, watchdog_timeout = 1'h0, lock_bit1 = 1'h0, external_fetch_select = 1'h1;
    logic rst_drv = 1'h0, awready, wready, bvalid, arready, rvalid, code_valid, core_reset, ale_o, ale_oe;
    logic program_fetch_strobe_n, rst_pin_o, rst_pin_oe, d_oe;
    logic [1:0] bresp, rresp;
    logic [7:0] code_byte, low_addr_data_port_o, low_addr_data_port_oe, high_addr_port_o, high_addr_port_oe;
    logic [7:0] p3_o, p3_oe, d_o, lad_last = 8'h00;
    // released port 0 lines show the memory's data while it drives them, else the inverse of their last level
    wire logic [7:0] low_addr_data_port_i = (low_addr_data_port_oe & low_addr_data_port_o)
        | (~low_addr_data_port_oe & (d_oe ? d_o : ~lad_last));
    wire logic [7:0] high_addr_port_i = (high_addr_port_oe & high_addr_port_o) | ~high_addr_port_oe;
    wire logic [7:0] p3_i = (p3_oe & p3_o) | ~p3_oe;
    wire logic rst_pin_i = rst_pin_oe ? rst_pin_o : rst_drv;
    int fails = 0, comparisons = 0, n_ale = 0, n_stb = 0, n_rst = 0, cyc = 0, t0;
    logic [7:0] d;
    logic [1:0] r;

    emb_ext_bus DUT (.*);
    emb_ext_mem MEM (.mclk(mclk), .ale(ale_oe ? ale_o : 1'h1), .ad(low_addr_data_port_i),
        .hi(high_addr_port_i), .wr_n(p3_i[6]), .rd_n(p3_i[7]), .fetch_n(program_fetch_strobe_n),
        .d_o(d_o), .d_oe(d_oe));

    always #12.5 mclk = ~mclk;
    // counted on the falling edge, where registered outputs have settled
    always @(negedge mclk) begin
        cyc++;
        n_ale += int'(ale_o & ale_oe);
        n_stb += int'(!program_fetch_strobe_n);
        n_rst += int'(rst_pin_oe);
    end
    always @(posedge mclk) lad_last <= low_addr_data_port_i;

    // ---------------------------------
    // tasks
    // ---------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic axw(input logic [7:0] idx, input logic [7:0] v);
        logic a, w;
        @(posedge mclk);
        a = 1'h1;
        w = 1'h1;
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, v};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (a || w) begin
            @(posedge mclk);
            if (a && awready) begin a = 1'h0; awvalid <= 1'h0; end
            if (w && wready) begin w = 1'h0; wvalid <= 1'h0; end
        end
        while (bvalid !== 1'h1) @(posedge mclk);
        bready <= 1'h0;
    endtask : axw
    task automatic axr(input logic [7:0] idx, output logic [7:0] v, output logic [1:0] rs);
        @(posedge mclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge mclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge mclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
        v = rdata[7:0];
        rs = rresp;
    endtask : axr
    task automatic xa(input logic [7:0] ctl);
        axw(emb_pkg::IDX_XCTL, ctl);
        do axr(emb_pkg::IDX_XSTA, d, r); while (d[0] !== 1'h0);
        axr(emb_pkg::IDX_XDAT, d, r);
    endtask : xa
    task automatic win(input int n);
        n_ale = 0;
        n_stb = 0;
        n_rst = 0;
        repeat (n) @(posedge mclk);
    endtask : win
    task automatic test_done;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done

    // ---------------------------------
    // tests
    // ---------------------------------
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'h1;
        axr(emb_pkg::IDX_AUX, d, r);
        chk(d, 8'h00);
        axr(8'h10, d, r);
        chk({r, d}, {2'h2, 8'h00});
        axw(emb_pkg::IDX_AUX, 8'hff);
        axr(emb_pkg::IDX_AUX, d, r);
        chk(d, 8'h1b);
        axw(emb_pkg::IDX_AUX, 8'h02);
        win(72);
        chk(n_ale, 12);
        chk(n_stb, 0);
        axw(emb_pkg::IDX_XADL, 8'h34);
        axw(emb_pkg::IDX_XADH, 8'h12);
        axw(emb_pkg::IDX_XDAT, 8'h5a);
        xa(8'h07);
        chk(MEM.peek(16'h1234), 8'h5a);
        axw(emb_pkg::IDX_XADH, 8'h77);
        axw(emb_pkg::IDX_HIGH_PORT, 8'h12);
        xa(8'h01);
        chk(d, 8'h5a);
        xa(8'h05);
        chk(d, 8'h43);
        axw(emb_pkg::IDX_AUX, 8'h00);
        axw(emb_pkg::IDX_XADH, 8'h00);
        axw(emb_pkg::IDX_XDAT, 8'h99);
        xa(8'h03);
        axw(emb_pkg::IDX_XDAT, 8'h00);
        xa(8'h01);
        chk({MEM.mem.exists(16'h0034), d}, {1'h0, 8'h99});
        axw(emb_pkg::IDX_AUX, 8'h03);
        win(36);
        chk({ale_oe, 5'(n_ale)}, {1'h0, 5'h00});
        code_move_active <= 1'h1;
        @(posedge mclk);
        win(36);
        chk(n_ale, 6);
        code_move_active <= 1'h0;
        external_fetch_select <= 1'h0;
        win(12);
        win(36);
        chk(n_ale, 6);
        do @(posedge mclk); while (code_valid !== 1'h1);
        chk(code_byte, 8'h5a);
        win(72);
        chk(n_stb, 24);
        axw(emb_pkg::IDX_XADH, 8'h12);
        t0 = cyc;
        win(0);
        axw(emb_pkg::IDX_XCTL, 8'h05);
        while (cyc < t0 + 72) @(posedge mclk);
        chk(n_ale, 11);
        chk(n_stb, 22);
        external_fetch_select <= 1'h1;
        watchdog_timeout <= 1'h1;
        @(posedge mclk);
        watchdog_timeout <= 1'h0;
        win(120);
        chk(n_rst, 98);
        axw(emb_pkg::IDX_AUX, 8'h08);
        watchdog_timeout <= 1'h1;
        @(posedge mclk);
        watchdog_timeout <= 1'h0;
        win(120);
        chk(n_rst, 0);
        lock_bit1 <= 1'h1;
        external_fetch_select <= 1'h0;
        axr(emb_pkg::IDX_XSTA, d, r);
        chk(d[1], 1'h0);
        lock_bit1 <= 1'h0;
        axr(emb_pkg::IDX_XSTA, d, r);
        chk(d[1], 1'h1);
        external_fetch_select <= 1'h1;
        rst_drv <= 1'h1;
        repeat (11) @(posedge mclk);
        @(negedge mclk);
        chk(core_reset, 1'h0);
        @(negedge mclk);
        chk(core_reset, 1'h1);
        @(posedge mclk);
        rst_drv <= 1'h0;
        test_done;
    end
endmodule : emb_ext_bus_bench

/* File: tb/emb_ext_mem.sv */
// external program and data memory behind an address latch
`timescale 1ns/1ps
module emb_ext_mem (
    // clock
    input wire logic mclk,
    // pin levels on the wires
    input wire logic ale,
    input wire logic [7:0] ad,
    input wire logic [7:0] hi,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic fetch_n,
    // drive toward the multiplexed port
    output logic [7:0] d_o,
    output logic d_oe
);
    logic [7:0] mem [int];
    logic [7:0] lo_latch = 8'h00;
    // unwritten cells return a pattern derived from the address
    function automatic logic [7:0] peek(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8];
    endfunction : peek
    // the edge that ends the latch pulse is its falling edge
    always @(posedge mclk) begin
        if (ale) lo_latch <= ad;
        if (!wr_n) mem[{hi, lo_latch}] = ad;
        d_o <= peek({hi, lo_latch});
    end
    assign d_oe = !rd_n || !fetch_n;
endmodule : emb_ext_mem
